/* File: ppmux_checker.sv */
// Checker for the port pin mux
// Assumes a bind onto the mux top module
`timescale 1ns/1ps
module ppmux_checker
   import ppmux_pkg::*;
(
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire ppmux_sel_type p72_sel_i, // In
   input wire ppmux_sel_type p70_sel_i, // In
   input wire logic analog_mux_ctl0_i, // In
   input wire logic jtag_tdo_i, // In
   input wire logic jtag_tdo_en_i, // In
   input wire logic port7_bit2_pad_i, // In
   input wire logic port7_bit0_pad_i, // In
   input wire logic power_on_reset_pin_i, // In
   input wire logic debug_reset_pin_i, // In
   input wire logic port7_bit2_o, // Out
   input wire logic port7_bit2_oe_o, // Out
   input wire logic port7_bit0_o, // Out
   input wire logic port7_bit0_oe_o, // Out
   input wire logic pwm_unit2_position0_in_o, // Out
   input wire logic jtag_tdi_c_o, // Out
   input wire logic service_request2_trigger1_o, // Out
   input wire logic can4_receive_in_b_o, // Out
   input wire logic debug_enable_o, // Out
   input wire logic debug_system_reset_o // Out
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_alt_one: assert property (p72_sel_i[3] && p72_sel_i[1:0] == 2'h1
      |=> port7_bit2_o == $past(analog_mux_ctl0_i))
      else $error("bit2 alt one wrong");
   a_alt_three: assert property (p72_sel_i[3] && p72_sel_i[1:0] == 2'h3
      |=> port7_bit2_oe_o && !port7_bit2_o)
      else $error("bit2 alt three wrong");
   a_drv_off: assert property (!p72_sel_i[3] |=> !port7_bit2_oe_o)
      else $error("bit2 driver on");
   a_bit0_off: assert property (!jtag_tdo_en_i && !p70_sel_i[3] |=> !port7_bit0_oe_o)
      else $error("bit0 driver on");
   a_hw_owns: assert property (jtag_tdo_en_i |=> port7_bit0_oe_o && port7_bit0_o == $past(jtag_tdo_i))
      else $error("bit0 not owned");
   a_fan_two: assert property (1 |=> pwm_unit2_position0_in_o == $past(port7_bit2_pad_i)
      && jtag_tdi_c_o == $past(port7_bit2_pad_i))
      else $error("bit2 fanout wrong");
   a_fan_zero: assert property (1 |=> service_request2_trigger1_o == $past(port7_bit0_pad_i)
      && can4_receive_in_b_o == $past(port7_bit0_pad_i))
      else $error("bit0 fanout wrong");
   a_strap_high: assert property ($rose(power_on_reset_pin_i) && debug_reset_pin_i |=> debug_enable_o)
      else $error("strap not taken");
   a_por_hold: assert property (!power_on_reset_pin_i |=> debug_system_reset_o && !debug_enable_o)
      else $error("debug not held in reset");
   a_dbg_follow: assert property (debug_enable_o && power_on_reset_pin_i
      |=> debug_system_reset_o == !$past(debug_reset_pin_i))
      else $error("debug reset not following pin");
endmodule : ppmux_checker

/* File: ppmux_defs.svh */
// Constants for the port pin output select multiplexer
// Assumes inclusion by the package and the design module
`ifndef PPMUX_DEFS_SVH
`define PPMUX_DEFS_SVH
// --------------------------------------------------
// Output select field layout
// --------------------------------------------------
`define PPMUX_SEL_W 4
`define PPMUX_SEL_EN_BIT 3
`define PPMUX_SEL_RST 4'h0
`define PPMUX_ALT_W 2
// --------------------------------------------------
// Alternate output codes
// --------------------------------------------------
`define PPMUX_ALT0 2'h0
`define PPMUX_ALT1 2'h1
`define PPMUX_ALT2 2'h2
`define PPMUX_ALT3 2'h3
`endif

/* File: ppmux_partner.sv */
// Board model: pads, test pin, debugger
// Assumes the mux pad outputs
`timescale 1ns/1ps
module ppmux_partner (
   input wire logic drv2_i, // Bit2 out
   input wire logic oe2_i, // Bit2 enable
   input wire logic drv0_i, // Bit0 out
   input wire logic oe0_i, // Bit0 enable
   input wire logic [1:0] ext_i, // Board levels
   input wire logic dbg_want_i, // Debugger on
   output logic pad2_o, // Bit2 pad
   output logic pad0_o, // Bit0 pad
   output logic test_pin_o, // Test pin
   output logic dbg_pin_o // Debug reset pin
);
   assign test_pin_o = 1'h1;
   assign dbg_pin_o = dbg_want_i;
   assign pad2_o = oe2_i ? drv2_i : ext_i[1];
   assign pad0_o = oe0_i ? drv0_i : ext_i[0];
endmodule : ppmux_partner

/* File: ppmux_pkg.sv */
// Types for the port pin output select multiplexer
// Assumes the constants header is on the include path
`include "ppmux_defs.svh"
package ppmux_pkg;
   typedef logic [`PPMUX_SEL_W-1:0] ppmux_sel_type;
   typedef enum logic [1:0] {
      PPMUX_DBG_WAIT = 2'b00,
      PPMUX_DBG_ON = 2'b01,
      PPMUX_DBG_OFF = 2'b10
   } ppmux_dbg_type;
endpackage : ppmux_pkg

/* File: ppmux_port_pin_output_select_mux.sv */
// Output select and input fan-out for port7 bit2 and bit0, plus debug reset strap capture
// Assumes all inputs synchronous to clk_i and the power-on reset pin already synchronised
// How it works
// - Select code 1x00 picks alt zero, onward
// - Hardware owned output overrides software select
// - Bit2 alts: gpio, analog mux, can4 transmit
// - Bit2 pad feeds port, pwm, test input
// - Bit0 alts: timers 3, 6; test output owned
// - Bit0 pad feeds port, service request, can4
// - Sample debug reset at power-on release
`timescale 1ns/1ps
`include "ppmux_defs.svh"
module ppmux_port_pin_output_select_mux
   import ppmux_pkg::*;
(
   input wire logic clk_i, // System clock, 25 MHz
   input wire logic rst_i, // Async reset, active high
   input wire logic [`PPMUX_SEL_W-1:0] p72_sel_i, // Bit2 output select field
   input wire logic [`PPMUX_SEL_W-1:0] p70_sel_i, // Bit0 output select field
   input wire logic p72_gpio_out_i, // Bit2 general output
   input wire logic analog_mux_ctl0_i, // Analog mux control 0
   input wire logic can4_transmit_out_i, // CAN4 transmit data
   input wire logic p70_gpio_out_i, // Bit0 general output
   input wire logic timer3_toggle_out_i, // Timer 3 toggle latch
   input wire logic timer6_toggle_out_i, // Timer 6 toggle latch
   input wire logic jtag_tdo_i, // Test data output value
   input wire logic jtag_tdo_en_i, // Test data output owns pad
   input wire logic port7_bit2_pad_i, // Bit2 pad level
   input wire logic port7_bit0_pad_i, // Bit0 pad level
   input wire logic factory_test_enable_pin_i, // Factory test pin, low = test
   input wire logic power_on_reset_pin_i, // Power-on reset, low = reset
   input wire logic debug_reset_pin_i, // Debug reset pin
   output logic port7_bit2_o, // Bit2 pad output
   output logic port7_bit2_oe_o, // Bit2 pad output enable
   output logic port7_bit0_o, // Bit0 pad output
   output logic port7_bit0_oe_o, // Bit0 pad output enable
   output logic p72_port_in_o, // Bit2 port input
   output logic pwm_unit2_position0_in_o, // PWM unit 2 position 0
   output logic jtag_tdi_c_o, // Test data input variant C
   output logic p70_port_in_o, // Bit0 port input
   output logic service_request2_trigger1_o, // Service request 2 trigger 1
   output logic can4_receive_in_b_o, // CAN4 receive variant B
   output logic factory_test_mode_o, // Factory test mode active
   output logic debug_enable_o, // Debug system enabled
   output logic debug_system_reset_o // Debug system held in reset
);
   // --------------------------------------------------
   // Bit2 output selection
   // --------------------------------------------------
   logic p72_reg, p72_next, p72_oe_reg, p72_oe_next;
   logic [`PPMUX_ALT_W-1:0] p72_alt;

   always_comb begin
      p72_alt = p72_sel_i[`PPMUX_ALT_W-1:0];
      case (p72_alt)
         `PPMUX_ALT0: p72_next = p72_gpio_out_i;
         `PPMUX_ALT1: p72_next = analog_mux_ctl0_i;
         `PPMUX_ALT2: p72_next = can4_transmit_out_i;
         default: p72_next = 1'b0;
      endcase
      p72_oe_next = p72_sel_i[`PPMUX_SEL_EN_BIT];
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         p72_reg <= 1'b0;
         p72_oe_reg <= 1'b0;
      end else begin
         p72_reg <= p72_next;
         p72_oe_reg <= p72_oe_next;
      end
   end

   // --------------------------------------------------
   // Bit0 output selection
   // --------------------------------------------------
   logic p70_reg, p70_next, p70_oe_reg, p70_oe_next;
   logic [`PPMUX_ALT_W-1:0] p70_alt;

   always_comb begin
      p70_alt = p70_sel_i[`PPMUX_ALT_W-1:0];
      case (p70_alt)
         `PPMUX_ALT0: p70_next = p70_gpio_out_i;
         `PPMUX_ALT1: p70_next = timer3_toggle_out_i;
         `PPMUX_ALT2: p70_next = timer6_toggle_out_i;
         default: p70_next = 1'b0;
      endcase
      p70_oe_next = p70_sel_i[`PPMUX_SEL_EN_BIT];
      if (jtag_tdo_en_i) begin
         p70_next = jtag_tdo_i;
         p70_oe_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         p70_reg <= 1'b0;
         p70_oe_reg <= 1'b0;
      end else begin
         p70_reg <= p70_next;
         p70_oe_reg <= p70_oe_next;
      end
   end

   // --------------------------------------------------
   // Input fan-out
   // --------------------------------------------------
   localparam int FAN_N = 6;
   logic [FAN_N-1:0] fan_src;
   wire logic [FAN_N-1:0] fan_q;

   always_comb begin
      fan_src[0] = port7_bit2_pad_i;
      fan_src[1] = port7_bit2_pad_i;
      fan_src[2] = port7_bit2_pad_i;
      fan_src[3] = port7_bit0_pad_i;
      fan_src[4] = port7_bit0_pad_i;
      fan_src[5] = port7_bit0_pad_i;
   end

   // One input flop per fan-out line
   for (genvar fan_idx = 0; fan_idx < FAN_N; fan_idx++) begin : g_fan
      logic fan_reg, fan_next;

      always_comb begin
         fan_next = fan_src[fan_idx];
      end

      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            fan_reg <= 1'b0;
         end else begin
            fan_reg <= fan_next;
         end
      end

      assign fan_q[fan_idx] = fan_reg;
   end

   // --------------------------------------------------
   // Test and debug strap
   // --------------------------------------------------
   ppmux_dbg_type dbg_reg, dbg_next;
   logic por_d_reg, por_d_next;
   logic test_reg, test_next;
   logic trst_reg, trst_next;
   logic den_reg, den_next;

   always_comb begin
      por_d_next = power_on_reset_pin_i;
      test_next = ~factory_test_enable_pin_i;
      dbg_next = dbg_reg;
      trst_next = trst_reg;
      if (!power_on_reset_pin_i) begin
         dbg_next = PPMUX_DBG_WAIT;
         trst_next = 1'b1;
      end else begin
         case (dbg_reg)
            PPMUX_DBG_WAIT: begin
               if (!por_d_reg) begin
                  dbg_next = debug_reset_pin_i ? PPMUX_DBG_ON : PPMUX_DBG_OFF;
               end
            end
            PPMUX_DBG_ON: begin
               trst_next = ~debug_reset_pin_i;
            end
            PPMUX_DBG_OFF: begin
               trst_next = 1'b1;
            end
            default: dbg_next = PPMUX_DBG_WAIT;
         endcase
      end
      den_next = (dbg_next == PPMUX_DBG_ON);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dbg_reg <= PPMUX_DBG_WAIT;
         por_d_reg <= 1'b0;
         test_reg <= 1'b0;
         trst_reg <= 1'b1;
         den_reg <= 1'b0;
      end else begin
         dbg_reg <= dbg_next;
         por_d_reg <= por_d_next;
         test_reg <= test_next;
         trst_reg <= trst_next;
         den_reg <= den_next;
      end
   end

   // --------------------------------------------------
   // Outputs
   // --------------------------------------------------
   assign port7_bit2_o = p72_reg;
   assign port7_bit2_oe_o = p72_oe_reg;
   assign port7_bit0_o = p70_reg;
   assign port7_bit0_oe_o = p70_oe_reg;
   assign p72_port_in_o = fan_q[0];
   assign pwm_unit2_position0_in_o = fan_q[1];
   assign jtag_tdi_c_o = fan_q[2];
   assign p70_port_in_o = fan_q[3];
   assign service_request2_trigger1_o = fan_q[4];
   assign can4_receive_in_b_o = fan_q[5];
   assign factory_test_mode_o = test_reg;
   assign debug_enable_o = den_reg;
   assign debug_system_reset_o = trst_reg;
endmodule : ppmux_port_pin_output_select_mux

/* File: ppmux_port_pin_output_select_mux_bench.sv */
// Bench for the port pin mux
// Assumes package, partner and checker compiled first
`timescale 1ns/1ps
module ppmux_port_pin_output_select_mux_bench;
   import ppmux_pkg::*;
   logic clk_i = 1'h0, rst_i = 1'h1, tdo = 1'h0, tdo_en = 1'h0, por = 1'h1, dbg_want = 1'h0;
   ppmux_sel_type sel2 = 4'h0, sel0 = 4'h0;
   logic [2:0] s2 = 3'h0, s0 = 3'h0;
   logic [1:0] ext = 2'h0;
   logic b2, b2oe, b0, b0oe, pad2, pad0, tpin, dpin, pin2, pwm, tdi, pin0, esr, crx, ftm, den, dsr;
   int err_total = 0, samples_checked = 0, cyc = 0;
   ppmux_port_pin_output_select_mux dut (.clk_i(clk_i), .rst_i(rst_i), .p72_sel_i(sel2), .p70_sel_i(sel0),
      .p72_gpio_out_i(s2[0]), .analog_mux_ctl0_i(s2[1]), .can4_transmit_out_i(s2[2]), .p70_gpio_out_i(s0[0]),
      .timer3_toggle_out_i(s0[1]), .timer6_toggle_out_i(s0[2]), .jtag_tdo_i(tdo), .jtag_tdo_en_i(tdo_en),
      .port7_bit2_pad_i(pad2), .port7_bit0_pad_i(pad0), .factory_test_enable_pin_i(tpin),
      .power_on_reset_pin_i(por), .debug_reset_pin_i(dpin), .port7_bit2_o(b2), .port7_bit2_oe_o(b2oe),
      .port7_bit0_o(b0), .port7_bit0_oe_o(b0oe), .p72_port_in_o(pin2), .pwm_unit2_position0_in_o(pwm),
      .jtag_tdi_c_o(tdi), .p70_port_in_o(pin0), .service_request2_trigger1_o(esr), .can4_receive_in_b_o(crx),
      .factory_test_mode_o(ftm), .debug_enable_o(den), .debug_system_reset_o(dsr));
   ppmux_partner board (.drv2_i(b2), .oe2_i(b2oe), .drv0_i(b0), .oe0_i(b0oe), .ext_i(ext),
      .dbg_want_i(dbg_want), .pad2_o(pad2), .pad0_o(pad0), .test_pin_o(tpin), .dbg_pin_o(dpin));
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   task chk(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %b got %b", n, e, g);
      end
   endtask : chk
   task settle;
      @(posedge clk_i);
      #1;
   endtask : settle
   task t_mux;
      for (int c = 0; c < 48; c++) begin
         @(posedge clk_i);
         sel2 <= c[3:0];
         sel0 <= c[3:0];
         s2 <= 3'h1 << c[5:4];
         s0 <= 3'h1 << c[5:4];
         settle();
         chk("oe2", c[3], b2oe);
         chk("oe0", c[3], b0oe);
         if (c[3]) begin
            chk("out2", c[1:0] == c[5:4], b2);
            chk("out0", c[1:0] == c[5:4], b0);
         end
      end
   endtask : t_mux
   task t_own;
      for (int v = 0; v < 2; v++) begin
         @(posedge clk_i);
         sel0 <= 4'h0;
         tdo_en <= 1'h1;
         tdo <= v[0];
         settle();
         chk("own_oe", 1'h1, b0oe);
         chk("own_out", v[0], b0);
      end
      @(posedge clk_i);
      tdo_en <= 1'h0;
      settle();
      chk("own_off", 1'h0, b0oe);
   endtask : t_own
   task t_fan;
      for (int v = 0; v < 4; v++) begin
         @(posedge clk_i);
         sel2 <= 4'h0;
         sel0 <= 4'h0;
         ext <= v[1:0];
         settle();
         settle();
         chk("port2", v[1], pin2);
         chk("pwm", v[1], pwm);
         chk("tdi", v[1], tdi);
         chk("port0", v[0], pin0);
         chk("esr", v[0], esr);
         chk("crx", v[0], crx);
         chk("test", 1'h0, ftm);
      end
   endtask : t_fan
   task t_dbg(input logic strap);
      @(posedge clk_i);
      por <= 1'h0;
      dbg_want <= strap;
      settle();
      chk("dsr_por", 1'h1, dsr);
      chk("den_por", 1'h0, den);
      @(posedge clk_i);
      por <= 1'h1;
      settle();
      settle();
      chk("den", strap, den);
      chk("dsr", ~strap, dsr);
      @(posedge clk_i);
      dbg_want <= 1'h0;
      settle();
      settle();
      chk("dsr_low", 1'h1, dsr);
   endtask : t_dbg
   task close_out;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'h0;
      t_mux();
      t_own();
      t_fan();
      t_dbg(1'h1);
      t_dbg(1'h0);
      close_out();
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 1000) begin
         err_total++;
         close_out();
      end
   end
endmodule : ppmux_port_pin_output_select_mux_bench
bind ppmux_port_pin_output_select_mux ppmux_checker chk_i (.clk_i, .rst_i, .p72_sel_i, .p70_sel_i,
   .analog_mux_ctl0_i, .jtag_tdo_i, .jtag_tdo_en_i, .port7_bit2_pad_i, .port7_bit0_pad_i, .power_on_reset_pin_i,
   .debug_reset_pin_i, .port7_bit2_o, .port7_bit2_oe_o, .port7_bit0_o, .port7_bit0_oe_o, .pwm_unit2_position0_in_o,
   .jtag_tdi_c_o, .service_request2_trigger1_o, .can4_receive_in_b_o, .debug_enable_o, .debug_system_reset_o);
